//--- rtl/adc_tracking_mode_sequencer.sv
// Sequencer for tracking and conversion phases of a 12-bit SAR converter.
// Assumes convertStart is synchronous to clk; config inputs are static
// during an operation (they are sampled at convert-start).
// How it works
// - Mode 01b is post-tracking: tracking starts at convert-start.
// - Post-tracking converts only after the tracking interval elapses.
// - Post-tracking keeps the capacitor disconnected after conversion.
// - Mode 11b is dual-tracking: track at start, then convert.
// - Dual-tracking tracks continuously between conversions.
// - Tracking lasts tracking-time count plus two subsystem cycles.
// - Conversion is 13 divided clocks plus two subsystem cycles.
// - Pre-tracking converts at once with no tracking interval.
// - Conversion clock is subsystem clock divided by divider field plus one.
`timescale 1ns/1ps
module adc_tracking_mode_sequencer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       convertStart,
  input  wire logic [1:0] trackingModeSelect,
  input  wire logic [3:0] trackingTimeCount,
  input  wire logic [4:0] conversionClockDivider,
  output logic            sampleConnect,
  output logic            tracking,
  output logic            converting,
  output logic            sarClockTick,
  output logic            conversionDone
);
  // ==========================================================
  // State
  // ==========================================================
  track_seq_pkg::seq_state_e state_r;
  logic [1:0]  mode_r;
  logic [7:0]  trackCnt_r;
  logic [4:0]  divCnt_r;
  logic [4:0]  div_r;
  logic [3:0]  sarCnt_r;
  logic [1:0]  extraCnt_r;
  logic        startOk;
  logic        convEnd;
  logic        trackEnd;
  logic        divWrap;
  logic [8:0]  convLen_r;

  localparam int CNT_W = track_seq_pkg::CNT_W;

  // Start accepted only when idle; busy starts are dropped
  assign startOk  = convertStart && state_r == track_seq_pkg::ST_IDLE;
  assign trackEnd = state_r == track_seq_pkg::ST_TRACK &&
                    trackCnt_r == track_seq_pkg::CNT_ONE;
  assign convEnd  = state_r == track_seq_pkg::ST_CONV &&
                    sarCnt_r == track_seq_pkg::SAR_ZERO &&
                    extraCnt_r == track_seq_pkg::EXTRA_ONE;
  assign divWrap  = divCnt_r == div_r;

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r    <= track_seq_pkg::ST_IDLE;
      mode_r     <= track_seq_pkg::MODE_PRE;
      trackCnt_r <= track_seq_pkg::CNT_ZERO;
      div_r      <= track_seq_pkg::DIV_ZERO;
    end else begin
      case (state_r)
        track_seq_pkg::ST_IDLE: begin
          if (startOk) begin
            mode_r <= trackingModeSelect;
            div_r  <= conversionClockDivider;
            if (trackingModeSelect == track_seq_pkg::MODE_POST ||
                trackingModeSelect == track_seq_pkg::MODE_DUAL) begin
              state_r    <= track_seq_pkg::ST_TRACK;
              trackCnt_r <= CNT_W'(trackingTimeCount) +
                            CNT_W'(track_seq_pkg::TRACK_EXTRA);
            end else begin
              state_r <= track_seq_pkg::ST_CONV;
            end
          end
        end
        track_seq_pkg::ST_TRACK: begin
          trackCnt_r <= trackCnt_r - track_seq_pkg::CNT_ONE;
          if (trackEnd) begin
            state_r <= track_seq_pkg::ST_CONV;
          end
        end
        track_seq_pkg::ST_CONV: begin
          if (convEnd) begin
            state_r <= track_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= track_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Conversion timing: one start cycle, 13 SAR clocks, one end
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_r   <= track_seq_pkg::DIV_ZERO;
      sarCnt_r   <= track_seq_pkg::SAR_ZERO;
      extraCnt_r <= track_seq_pkg::EXTRA_ZERO;
    end else if (state_r != track_seq_pkg::ST_CONV) begin
      divCnt_r   <= track_seq_pkg::DIV_ZERO;
      sarCnt_r   <= track_seq_pkg::SAR_INIT;
      extraCnt_r <= track_seq_pkg::EXTRA_INIT;
    end else if (extraCnt_r == track_seq_pkg::EXTRA_INIT) begin
      extraCnt_r <= track_seq_pkg::EXTRA_ONE; // Start cycle
    end else if (sarCnt_r != track_seq_pkg::SAR_ZERO) begin
      // Divider period is field+1 subsystem clocks
      divCnt_r <= divWrap ? track_seq_pkg::DIV_ZERO
                          : divCnt_r + 5'h01;
      if (divWrap) begin
        sarCnt_r <= sarCnt_r - 4'h1;
      end
    end
  end

  // ==========================================================
  // Outputs, all registered
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampleConnect  <= 1'b0;
      tracking       <= 1'b0;
      converting     <= 1'b0;
      sarClockTick   <= 1'b0;
      conversionDone <= 1'b0;
    end else begin
      tracking       <= state_r == track_seq_pkg::ST_TRACK;
      converting     <= state_r == track_seq_pkg::ST_CONV;
      sarClockTick   <= state_r == track_seq_pkg::ST_CONV && divWrap &&
                        extraCnt_r == track_seq_pkg::EXTRA_ONE &&
                        sarCnt_r != track_seq_pkg::SAR_ZERO;
      conversionDone <= convEnd;
      // Dual mode keeps the cap on the input while idle; post leaves it open
      sampleConnect  <= state_r == track_seq_pkg::ST_TRACK ||
                        (state_r == track_seq_pkg::ST_IDLE &&
                         mode_r == track_seq_pkg::MODE_DUAL);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_busy_ignore;
    @(posedge clk) disable iff (!rst_n)
    (convertStart && state_r != track_seq_pkg::ST_IDLE && !convEnd)
      |=> state_r != track_seq_pkg::ST_IDLE || $past(convEnd);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("start accepted while busy");

  property p_post_start;
    @(posedge clk) disable iff (!rst_n)
    (startOk && trackingModeSelect == track_seq_pkg::MODE_POST)
      |=> state_r == track_seq_pkg::ST_TRACK;
  endproperty
  a_post_start: assert property (p_post_start)
    else $error("post mode did not start tracking");

  property p_dual_start;
    @(posedge clk) disable iff (!rst_n)
    (startOk && trackingModeSelect == track_seq_pkg::MODE_DUAL)
      |=> state_r == track_seq_pkg::ST_TRACK;
  endproperty
  a_dual_start: assert property (p_dual_start)
    else $error("dual mode did not start tracking");

  property p_pre_start;
    @(posedge clk) disable iff (!rst_n)
    (startOk && trackingModeSelect == track_seq_pkg::MODE_PRE)
      |=> state_r == track_seq_pkg::ST_CONV;
  endproperty
  a_pre_start: assert property (p_pre_start)
    else $error("pre mode did not convert at once");

  property p_track_len;
    @(posedge clk) disable iff (!rst_n)
    (startOk && trackingModeSelect == track_seq_pkg::MODE_POST &&
     trackingTimeCount == 4'h0)
      |=> state_r == track_seq_pkg::ST_TRACK ##1
          state_r == track_seq_pkg::ST_TRACK ##1
          state_r == track_seq_pkg::ST_CONV;
  endproperty
  a_track_len: assert property (p_track_len)
    else $error("tracking length wrong");

  // Cycles spent converting; a counter keeps the length checks cheap
  always_ff @(posedge clk) begin
    if (!rst_n || state_r != track_seq_pkg::ST_CONV) begin
      convLen_r <= 9'h000;
    end else begin
      convLen_r <= convLen_r + 9'h001;
    end
  end

  property p_conv_len;
    @(posedge clk) disable iff (!rst_n)
    (startOk && trackingModeSelect == track_seq_pkg::MODE_PRE &&
     conversionClockDivider == 5'h00)
      |=> ##14 (convEnd && convLen_r == 9'h00E) ##1
          state_r == track_seq_pkg::ST_IDLE;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_conv_any;
    @(posedge clk) disable iff (!rst_n)
    convEnd |-> convLen_r ==
      9'(track_seq_pkg::SAR_CYCLES * (int'(div_r) + 1) + 1);
  endproperty
  a_conv_any: assert property (p_conv_any)
    else $error("conversion length does not follow divider");

  property p_post_open;
    @(posedge clk) disable iff (!rst_n)
    (convEnd && mode_r == track_seq_pkg::MODE_POST) |=> ##1 !sampleConnect;
  endproperty
  a_post_open: assert property (p_post_open)
    else $error("post mode capacitor still connected");

  property p_dual_track;
    @(posedge clk) disable iff (!rst_n)
    (convEnd && mode_r == track_seq_pkg::MODE_DUAL) |=> ##1 sampleConnect;
  endproperty
  a_dual_track: assert property (p_dual_track)
    else $error("dual mode not tracking after conversion");

  property p_tick_gap;
    @(posedge clk) disable iff (!rst_n)
    (sarClockTick && div_r == 5'h01) |=> !sarClockTick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("conversion clock not divided");

  c_post: cover property (@(posedge clk) startOk &&
    trackingModeSelect == track_seq_pkg::MODE_POST);
  c_dual_done: cover property (@(posedge clk) conversionDone &&
    mode_r == track_seq_pkg::MODE_DUAL);
  c_busy: cover property (@(posedge clk) convertStart &&
    state_r == track_seq_pkg::ST_CONV);
endmodule : adc_tracking_mode_sequencer

//--- include/track_seq_pkg.sv
// Constants for the converter tracking and conversion sequencer.
// Assumes a single 200 MHz subsystem clock drives every user.
package track_seq_pkg;
  localparam int          MODE_W        = 2;
  localparam int          TRACKTIME_W   = 4;
  localparam int          DIV_W         = 5;
  localparam logic [1:0]  MODE_PRE      = 2'h0;
  localparam logic [1:0]  MODE_POST     = 2'h1;
  localparam logic [1:0]  MODE_DUAL     = 2'h3;
  localparam int          TRACK_EXTRA   = 2;
  localparam int          SAR_CYCLES    = 13;
  localparam int          CONV_EXTRA    = 2;
  localparam int          CNT_W         = 8;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  localparam logic [7:0]  CNT_ONE       = 8'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  localparam logic [3:0]  SAR_INIT      = 4'hD;
  localparam logic [3:0]  SAR_ZERO      = 4'h0;
  localparam logic [1:0]  EXTRA_INIT    = 2'h2;
  localparam logic [1:0]  EXTRA_ZERO    = 2'h0;
  localparam logic [1:0]  EXTRA_ONE     = 2'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} seq_state_e;
endpackage : track_seq_pkg

//--- verif/sample_cap_model.sv
// Sampling capacitor behind the input multiplexer, seen from the sequencer.
// Assumes analogIn is a settled digital stand-in for the input level.
`timescale 1ns/1ps
module sample_cap_model (
  input  wire logic        clk,
  input  wire logic        sampleConnect,
  input  wire logic [11:0] analogIn,
  output logic      [11:0] heldLevel
);
  // ==========================================================
  // Capacitor
  // Disconnected cap keeps its charge; the pin is left floating
  always_ff @(posedge clk) begin
    if (sampleConnect) begin
      heldLevel <= analogIn;
    end
  end
endmodule : sample_cap_model

//--- verif/adc_tracking_mode_sequencer_bench.sv
// Self-checking bench for the tracking and conversion sequencer.
// Assumes the capacitor model above and a 200 MHz clock.
`timescale 1ns/1ps
module adc_tracking_mode_sequencer_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        convertStart = 1'b0;
  logic [1:0]  trackingModeSelect = 2'h0;
  logic [3:0]  trackingTimeCount = 4'h0;
  logic [4:0]  conversionClockDivider = 5'h00;
  logic [11:0] analogIn = 12'h000;
  logic        sampleConnect, tracking, converting, sarClockTick;
  logic        conversionDone;
  logic [11:0] heldLevel;
  int          errors = 0;
  int          n_tests = 0;
  int          nt, nc, nk;

  adc_tracking_mode_sequencer u_adc_tracking_mode_sequencer (
    .clk(clk), .rst_n(rst_n), .convertStart(convertStart),
    .trackingModeSelect(trackingModeSelect),
    .trackingTimeCount(trackingTimeCount),
    .conversionClockDivider(conversionClockDivider),
    .sampleConnect(sampleConnect), .tracking(tracking),
    .converting(converting), .sarClockTick(sarClockTick),
    .conversionDone(conversionDone));
  sample_cap_model u_sample_cap_model (
    .clk(clk), .sampleConnect(sampleConnect), .analogIn(analogIn),
    .heldLevel(heldLevel));

  initial begin
    forever #2.5 clk = ~clk;
  end
  // Input level moves every cycle so a floating cap would show it
  always @(posedge clk) #1 analogIn = analogIn + 12'h001;

  // ==========================================================
  // Checking
  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_cnt
  task automatic check_bit(input logic got, input logic exp);
    check_val({11'h000, got}, {11'h000, exp});
  endtask : check_bit
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // One operation: start, count phases, then watch the idle gap
  task automatic run_op(input logic [1:0] m, input logic [3:0] tk,
                        input logic [4:0] dv, input bit mid,
                        input logic expConn);
    int          guard;
    logic [11:0] snap;
    trackingModeSelect = m;
    trackingTimeCount = tk;
    conversionClockDivider = dv;
    convertStart = 1'b1;
    @(posedge clk);
    #1 convertStart = 1'b0;
    nt = 0; nc = 0; nk = 0; guard = 0;
    while (conversionDone !== 1'b1 && guard < 2000) begin
      @(posedge clk);
      #1 guard++;
      nt += (tracking === 1'b1);
      nc += (converting === 1'b1);
      nk += (sarClockTick === 1'b1);
      check_bit(tracking & converting, 1'b0);
      convertStart = (mid && nc == 3);
    end
    if (guard >= 2000) errors++;
    snap = heldLevel;
    repeat (4) begin
      @(posedge clk);
      #1 nt += (tracking === 1'b1);
      nc += (converting === 1'b1);
      check_bit(sampleConnect, expConn);
    end
    if (expConn === 1'b0 && m != 2'h0 && m != 2'h2)
      check_val(heldLevel, snap);
  endtask : run_op

  // ==========================================================
  // Scenarios
  task automatic t_post;
    run_op(track_seq_pkg::MODE_POST, 4'h3, 5'h01, 1'b0, 1'b0);
    check_cnt(nt, 5);
    check_cnt(nc, 2 + 13 * 2);
    check_cnt(nk, 13);
  endtask : t_post
  task automatic t_dual;
    // Longest tracking count, as after a channel change
    run_op(track_seq_pkg::MODE_DUAL, 4'hF, 5'h00, 1'b0, 1'b1);
    check_cnt(nt, 17);
    check_cnt(nc, 15);
    check_cnt(nk, 13);
  endtask : t_dual
  task automatic t_pre;
    logic [1:0] modes [2] = '{2'h0, 2'h2};
    logic [4:0] divs [2]  = '{5'h00, 5'h1F};
    foreach (modes[i]) begin
      run_op(modes[i], 4'h7, divs[i], 1'b0, 1'b0);
      check_cnt(nt, 0);
      check_cnt(nc, 2 + 13 * (int'(divs[i]) + 1));
    end
  endtask : t_pre
  task automatic t_ignore;
    run_op(track_seq_pkg::MODE_POST, 4'h0, 5'h02, 1'b1, 1'b0);
    check_cnt(nt, 2);
    check_cnt(nc, 2 + 13 * 3);
  endtask : t_ignore

  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_post();
    t_dual();
    t_pre();
    t_ignore();
    end_of_test();
  end
  initial begin
    #50000;
    errors++;
    end_of_test();
  end
endmodule : adc_tracking_mode_sequencer_bench
